// *** mcr_bank.v ***
// What this block does
// R1 - channel b gains reset to 0x400000
// R2 - channel b offsets reset zero, signed
// R3 - host never writes reserved or voltage gain
// R4 - read-only copy of last transfer data
// R5 - noload bits 0-2 disable detection
// R6 - line-cycle bits 0-5 enable accumulation
// R7 - bit 6 enables clear-on-read, resets one
// R8 - config bits 0,1 enable integrators
// R9 - config bit 2 enables highpass, resets one
// R10 - bit 3 picks power factor source
// R11 - bit 4 picks reverse-power pulse source
// R12 - bit 5 level or 1 Hz reverse pin
// R13 - bit 6 bypasses zero-cross filter
// R14 - writing bit 7 triggers software reset
// R15 - bit 11 picks current zero-cross channel
// R16 - bits 13:12 pick zero-cross irq edge
// R17 - bit 15 clear enables comm locking
// R18 - bit 8 enables register checksum
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "mcr_regs.vh"
module mcr_bank #(
  parameter REVERSE_POWER_PIN_HALF = `MCR_REVERSE_POWER_PIN_HALF
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [13:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // datapath status
  input wire rev_polarity_one_i,
  input wire rev_polarity_two_i,
  input wire voltage_zero_cross_i,
  input wire zx_positive_i,
  // configuration outputs
  output reg [2:0] noload_off_o,
  output reg [5:0] cycle_accum_o,
  output reg clear_on_read_enable_o,
  output reg chan_a_integrator_on_o,
  output reg chan_b_integrator_on_o,
  output reg highpass_filter_on_o,
  output reg power_factor_source_o,
  output reg zero_cross_filter_bypass_o,
  output reg checksum_on_o,
  output reg current_zero_cross_source_o,
  output reg [1:0] zero_cross_irq_edge_o,
  output reg disable_a_on_o,
  output reg soft_reset_request_o,
  output reg reverse_power_pin_o,
  output reg zero_cross_irq_o,
  output reg irq_o,
  // gain and offset values
  output reg [23:0] chan_b_current_gain_o,
  output reg [23:0] chan_b_active_power_gain_o,
  output reg [23:0] chan_b_reactive_power_gain_o,
  output reg [23:0] chan_b_apparent_power_gain_o,
  output reg [23:0] chan_b_rms_current_offset_o,
  output reg [23:0] chan_b_active_power_offset_o,
  output reg [23:0] chan_b_reactive_power_offset_o,
  output reg [23:0] chan_b_apparent_power_offset_o
);
  reg [2:0] no_load_disable;
  reg [6:0] line_cycle_control;
  reg [15:0] main_configuration;
  reg [23:0] last_transfer_data;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [31:0] pulse_cnt;
  reg pulse_phase;
  reg zx_prev;
  reg [31:0] next_rdata;
  reg next_err;
  wire [11:0] idx = paddr_i[13:2];
  wire wr_acc = psel_i & penable_i & pwrite_i;
  wire rd_acc = psel_i & penable_i & ~pwrite_i;
  wire acc_done = psel_i & penable_i & pready_o;
  wire rev_sel;
  wire zx_rise;
  wire zx_fall;
  wire zx_event;
  wire [2:0] irq_set;

  // decode: 1 = readable and mapped
  function mapped;
    input [11:0] a;
    begin
      case (a)
        `MCR_IDX_NOLOAD, `MCR_IDX_LCYC, `MCR_IDX_CFG, `MCR_IDX_CHAN_B_CURRENT_GAIN,
        `MCR_IDX_CHAN_B_VOLTAGE_GAIN_FIXED, `MCR_IDX_CHAN_B_ACTIVE_POWER_GAIN, `MCR_IDX_CHAN_B_REACTIVE_POWER_GAIN, `MCR_IDX_CHAN_B_APPARENT_POWER_GAIN,
        `MCR_IDX_RSV_A, `MCR_IDX_CHAN_B_RMS_CURRENT_OFFSET, `MCR_IDX_RSV_B, `MCR_IDX_RSV_C,
        `MCR_IDX_CHAN_B_ACTIVE_POWER_OFFSET, `MCR_IDX_CHAN_B_REACTIVE_POWER_OFFSET, `MCR_IDX_CHAN_B_APPARENT_POWER_OFFSET, `MCR_IDX_LAST,
        `MCR_IDX_IRQ_STAT, `MCR_IDX_IRQ_MASK, `MCR_IDX_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  assign rev_sel = main_configuration[`MCR_CFG_REVERSE_POWER_PULSE_SOURCE] ? rev_polarity_two_i :
    rev_polarity_one_i; // R11
  assign zx_rise = voltage_zero_cross_i & ~zx_prev;
  assign zx_fall = ~voltage_zero_cross_i & zx_prev;
  // R16
  assign zx_event = (main_configuration[13:12] == 2'b01) ? zx_fall :
    (main_configuration[13:12] == 2'b10) ? zx_rise : (zx_rise | zx_fall);
  assign irq_set = {zx_event, rev_sel & ~reverse_power_pin_o & ~pulse_phase,
    wr_acc & pready_o & (idx == `MCR_IDX_CFG) & pwdata_i[`MCR_CFG_SOFT_RESET_REQUEST]};

  always @* begin
    next_rdata = 32'h00000000;
    next_err = ~mapped(idx);
    case (idx)
      `MCR_IDX_NOLOAD: next_rdata = {29'h0, no_load_disable};
      `MCR_IDX_LCYC: next_rdata = {25'h0, line_cycle_control};
      `MCR_IDX_CFG: next_rdata = {16'h0, main_configuration};
      `MCR_IDX_CHAN_B_CURRENT_GAIN: next_rdata = {8'h0, chan_b_current_gain_o};
      `MCR_IDX_CHAN_B_VOLTAGE_GAIN_FIXED: next_rdata = {8'h0, `MCR_GAIN_RST};
      `MCR_IDX_CHAN_B_ACTIVE_POWER_GAIN: next_rdata = {8'h0, chan_b_active_power_gain_o};
      `MCR_IDX_CHAN_B_REACTIVE_POWER_GAIN: next_rdata = {8'h0, chan_b_reactive_power_gain_o};
      `MCR_IDX_CHAN_B_APPARENT_POWER_GAIN: next_rdata = {8'h0, chan_b_apparent_power_gain_o};
      // R2 offsets read sign-extended
      `MCR_IDX_CHAN_B_RMS_CURRENT_OFFSET: next_rdata = {{8{chan_b_rms_current_offset_o[23]}},
        chan_b_rms_current_offset_o};
      `MCR_IDX_CHAN_B_ACTIVE_POWER_OFFSET: next_rdata = {{8{chan_b_active_power_offset_o[23]}},
        chan_b_active_power_offset_o};
      `MCR_IDX_CHAN_B_REACTIVE_POWER_OFFSET: next_rdata = {{8{chan_b_reactive_power_offset_o[23]}},
        chan_b_reactive_power_offset_o};
      `MCR_IDX_CHAN_B_APPARENT_POWER_OFFSET: next_rdata = {{8{chan_b_apparent_power_offset_o[23]}},
        chan_b_apparent_power_offset_o};
      `MCR_IDX_LAST: next_rdata = {8'h0, last_transfer_data}; // R4
      `MCR_IDX_IRQ_STAT: next_rdata = {29'h0, irq_status};
      `MCR_IDX_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      `MCR_IDX_STATUS: next_rdata = {30'h0, pulse_phase, reverse_power_pin_o};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // apb: one wait state; pready asserted in second access cycle
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      prdata_o <= (rd_acc & ~pready_o) ? next_rdata : 32'h00000000;
      pslverr_o <= psel_i & penable_i & ~pready_o & next_err;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      no_load_disable <= `MCR_NOLOAD_RST; // R5
      line_cycle_control <= `MCR_LCYC_RST; // R6 R7
      main_configuration <= `MCR_CFG_RST; // R9 R17
      chan_b_current_gain_o <= `MCR_GAIN_RST; // R1
      chan_b_active_power_gain_o <= `MCR_GAIN_RST;
      chan_b_reactive_power_gain_o <= `MCR_GAIN_RST;
      chan_b_apparent_power_gain_o <= `MCR_GAIN_RST;
      chan_b_rms_current_offset_o <= `MCR_OFS_RST; // R2
      chan_b_active_power_offset_o <= `MCR_OFS_RST;
      chan_b_reactive_power_offset_o <= `MCR_OFS_RST;
      chan_b_apparent_power_offset_o <= `MCR_OFS_RST;
      last_transfer_data <= 24'h000000;
      irq_status <= 3'h0;
      irq_mask <= 3'h0;
      soft_reset_request_o <= 1'b0;
    end else begin
      soft_reset_request_o <= irq_set[`MCR_IRQ_SOFT_RESET_REQUEST]; // R14
      if (acc_done & ~next_err)
        last_transfer_data <= pwrite_i ? pwdata_i[23:0] : prdata_o[23:0]; // R4
      if (irq_set[`MCR_IRQ_SOFT_RESET_REQUEST]) begin
        // software reset restores the configuration; soft_reset_request bit self-clears
        no_load_disable <= `MCR_NOLOAD_RST;
        line_cycle_control <= `MCR_LCYC_RST;
        main_configuration <= `MCR_CFG_RST; // R14
        chan_b_current_gain_o <= `MCR_GAIN_RST;
        chan_b_active_power_gain_o <= `MCR_GAIN_RST;
        chan_b_reactive_power_gain_o <= `MCR_GAIN_RST;
        chan_b_apparent_power_gain_o <= `MCR_GAIN_RST;
        chan_b_rms_current_offset_o <= `MCR_OFS_RST;
        chan_b_active_power_offset_o <= `MCR_OFS_RST;
        chan_b_reactive_power_offset_o <= `MCR_OFS_RST;
        chan_b_apparent_power_offset_o <= `MCR_OFS_RST;
      end else if (wr_acc & pready_o) begin
        // reserved slots and voltage gain are not writable
        case (idx)
          `MCR_IDX_NOLOAD: no_load_disable <= pwdata_i[2:0];
          `MCR_IDX_LCYC: line_cycle_control <= pwdata_i[6:0];
          `MCR_IDX_CFG: main_configuration <= {pwdata_i[15], 1'b0, pwdata_i[13:11],
            2'b00, pwdata_i[8], 1'b0, pwdata_i[6:0]};
          `MCR_IDX_CHAN_B_CURRENT_GAIN: chan_b_current_gain_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_ACTIVE_POWER_GAIN: chan_b_active_power_gain_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_REACTIVE_POWER_GAIN: chan_b_reactive_power_gain_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_APPARENT_POWER_GAIN: chan_b_apparent_power_gain_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_RMS_CURRENT_OFFSET: chan_b_rms_current_offset_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_ACTIVE_POWER_OFFSET: chan_b_active_power_offset_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_REACTIVE_POWER_OFFSET: chan_b_reactive_power_offset_o <= pwdata_i[23:0];
          `MCR_IDX_CHAN_B_APPARENT_POWER_OFFSET: chan_b_apparent_power_offset_o <= pwdata_i[23:0];
          `MCR_IDX_IRQ_MASK: irq_mask <= pwdata_i[2:0];
          default: irq_mask <= irq_mask;
        endcase
      end
      // set wins over write-one-to-clear
      if (wr_acc & pready_o & (idx == `MCR_IDX_IRQ_STAT))
        irq_status <= (irq_status & ~pwdata_i[2:0]) | irq_set;
      else
        irq_status <= irq_status | irq_set;
    end
  end

  // configuration decode to outputs
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      noload_off_o <= 3'h0;
      cycle_accum_o <= 6'h00;
      clear_on_read_enable_o <= 1'b1;
      chan_a_integrator_on_o <= 1'b0;
      chan_b_integrator_on_o <= 1'b0;
      highpass_filter_on_o <= 1'b1;
      power_factor_source_o <= 1'b0;
      zero_cross_filter_bypass_o <= 1'b0;
      checksum_on_o <= 1'b0;
      current_zero_cross_source_o <= 1'b0;
      zero_cross_irq_edge_o <= 2'b00;
      disable_a_on_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      noload_off_o <= no_load_disable; // R5
      cycle_accum_o <= line_cycle_control[5:0]; // R6
      clear_on_read_enable_o <= line_cycle_control[6]; // R7
      chan_a_integrator_on_o <= main_configuration[0]; // R8
      chan_b_integrator_on_o <= main_configuration[1]; // R8
      highpass_filter_on_o <= main_configuration[2]; // R9
      power_factor_source_o <= main_configuration[3]; // R10
      zero_cross_filter_bypass_o <= main_configuration[6]; // R13
      checksum_on_o <= main_configuration[8]; // R18
      current_zero_cross_source_o <= main_configuration[11]; // R15
      zero_cross_irq_edge_o <= main_configuration[13:12]; // R16
      disable_a_on_o <= ~main_configuration[15]; // R17
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // reverse-power pin and zero-cross event
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_cnt <= 32'h00000000;
      pulse_phase <= 1'b0;
      reverse_power_pin_o <= 1'b0;
      zx_prev <= 1'b0;
      zero_cross_irq_o <= 1'b0;
    end else begin
      zx_prev <= voltage_zero_cross_i;
      zero_cross_irq_o <= zx_event;
      if (!rev_sel) begin
        pulse_cnt <= 32'h00000000;
        pulse_phase <= 1'b0;
      end else if (pulse_cnt >= REVERSE_POWER_PIN_HALF - 1) begin
        pulse_cnt <= 32'h00000000;
        pulse_phase <= ~pulse_phase;
      end else begin
        pulse_cnt <= pulse_cnt + 32'h00000001;
      end
      // R12
      if (main_configuration[`MCR_CFG_REVERSE_POWER_PULSED_OUTPUT])
        reverse_power_pin_o <= rev_sel & ~pulse_phase;
      else
        reverse_power_pin_o <= rev_sel;
    end
  end
endmodule

// *** mcr_regs.vh ***
`ifndef MCR_REGS_VH
`define MCR_REGS_VH
// register indices as printed; byte address is index * 4
`define MCR_IDX_NOLOAD 12'h001
`define MCR_IDX_LCYC 12'h004
`define MCR_IDX_CFG 12'h102
`define MCR_IDX_CHAN_B_CURRENT_GAIN 12'h28c
`define MCR_IDX_CHAN_B_VOLTAGE_GAIN_FIXED 12'h28d
`define MCR_IDX_CHAN_B_ACTIVE_POWER_GAIN 12'h28e
`define MCR_IDX_CHAN_B_REACTIVE_POWER_GAIN 12'h28f
`define MCR_IDX_CHAN_B_APPARENT_POWER_GAIN 12'h290
`define MCR_IDX_RSV_A 12'h291
`define MCR_IDX_CHAN_B_RMS_CURRENT_OFFSET 12'h292
`define MCR_IDX_RSV_B 12'h293
`define MCR_IDX_RSV_C 12'h294
`define MCR_IDX_CHAN_B_ACTIVE_POWER_OFFSET 12'h295
`define MCR_IDX_CHAN_B_REACTIVE_POWER_OFFSET 12'h296
`define MCR_IDX_CHAN_B_APPARENT_POWER_OFFSET 12'h297
`define MCR_IDX_LAST 12'h2ff
`define MCR_IDX_IRQ_STAT 12'h3f0
`define MCR_IDX_IRQ_MASK 12'h3f1
`define MCR_IDX_STATUS 12'h3f2
// reset values
`define MCR_GAIN_RST 24'h400000
`define MCR_OFS_RST 24'h000000
`define MCR_NOLOAD_RST 3'h0
`define MCR_LCYC_RST 7'h40
`define MCR_CFG_RST 16'h8004
// configuration fields
`define MCR_CFG_SOFT_RESET_REQUEST 7
`define MCR_CFG_REVERSE_POWER_PULSE_SOURCE 4
`define MCR_CFG_REVERSE_POWER_PULSED_OUTPUT 5
// reverse-power pulse: 1 Hz at 50 MHz, half period
`define MCR_CLK_HZ 50000000
`define MCR_REVERSE_POWER_PIN_HZ 1
`define MCR_REVERSE_POWER_PIN_HALF (`MCR_CLK_HZ / (2 * `MCR_REVERSE_POWER_PIN_HZ))
// interrupt events
`define MCR_IRQ_SOFT_RESET_REQUEST 0
`define MCR_IRQ_REVERSE_POWER_PIN 1
`define MCR_IRQ_ZX 2
`endif

// *** mcr_bank_checker.sv ***
`timescale 1ns/1ps
module mcr_bank_checker (
  // clock, reset and bus
  input wire core_clk_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [13:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  // watched outputs
  input wire soft_reset_request_o,
  input wire highpass_filter_on_o,
  input wire disable_a_on_o,
  input wire chan_a_integrator_on_o,
  input wire chan_b_integrator_on_o,
  input wire clear_on_read_enable_o,
  input wire [2:0] noload_off_o,
  input wire [23:0] chan_b_current_gain_o,
  input wire [23:0] chan_b_active_power_offset_o
);
  wire cfg_wr;
  // completing write to the configuration word
  assign cfg_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i[13:2] == 12'h102;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ready_follows: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready late");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_soft_reset_request_pulse: assert property (cfg_wr && pwdata_i[7] |=> soft_reset_request_o ##1 !soft_reset_request_o)
    else $error("soft reset pulse wrong");
  a_hpf_follows: assert property (cfg_wr && !pwdata_i[7] |-> ##2 highpass_filter_on_o == $past(pwdata_i[2], 2))
    else $error("highpass wrong");
  a_integ_follows: assert property (cfg_wr && !pwdata_i[7] |-> ##2
    {chan_b_integrator_on_o, chan_a_integrator_on_o} == $past(pwdata_i[1:0], 2))
    else $error("integrator wrong");
  a_lock_inverse: assert property (cfg_wr && !pwdata_i[7] |-> ##2 disable_a_on_o != $past(pwdata_i[15], 2))
    else $error("lock wrong");
  a_gain_reset: assert property ($rose(rst_b_i) |-> chan_b_current_gain_o == 24'h400000)
    else $error("gain reset wrong");
  a_ofs_reset: assert property ($rose(rst_b_i) |-> chan_b_active_power_offset_o == 24'h000000)
    else $error("offset reset wrong");
  a_cfg_reset: assert property ($rose(rst_b_i) |-> noload_off_o == 3'h0 && clear_on_read_enable_o)
    else $error("config reset wrong");
endmodule
bind mcr_bank mcr_bank_checker u_chk (.*);

// *** mcr_host.sv ***
`timescale 1ns/1ps
module mcr_host (
  // clock and answer
  input wire core_clk_i,
  input wire pready_i,
  input wire pslverr_i,
  input wire [31:0] prdata_i,
  // request
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [13:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  task xfer(input logic w, input logic [11:0] i, input logic [31:0] d,
            output logic [31:0] r, output logic e, output logic t);
    int n;
    n = 0;
    r = 0;
    e = 0;
    t = 0;
    // never writes the reserved places or the fixed voltage gain
    if (w && i inside {12'h28d, 12'h291, 12'h293, 12'h294}) return;
    psel_o <= 1;
    pwrite_o <= w;
    paddr_o <= {i, 2'b00};
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!pready_i && n < 64);
    t = !pready_i;
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 0;
    penable_o <= 0;
    @(posedge core_clk_i);
  endtask
endmodule

// *** mcr_bank_tb.sv ***
`timescale 1ns/1ps
module mcr_bank_tb;
  logic core_clk_i = 0, rst_b_i = 0, zx_positive_i = 0, rerr, to;
  logic rev_polarity_one_i = 0, rev_polarity_two_i = 0, voltage_zero_cross_i = 0;
  wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  wire [13:0] paddr_i;
  wire [31:0] pwdata_i, prdata_o;
  wire [2:0] noload_off_o;
  wire [5:0] cycle_accum_o;
  wire [1:0] zero_cross_irq_edge_o;
  wire clear_on_read_enable_o, chan_a_integrator_on_o, chan_b_integrator_on_o, highpass_filter_on_o;
  wire power_factor_source_o, zero_cross_filter_bypass_o, checksum_on_o, disable_a_on_o;
  wire current_zero_cross_source_o, soft_reset_request_o, reverse_power_pin_o, zero_cross_irq_o;
  wire irq_o;
  wire [23:0] chan_b_current_gain_o, chan_b_active_power_gain_o, chan_b_reactive_power_gain_o;
  wire [23:0] chan_b_apparent_power_gain_o, chan_b_rms_current_offset_o;
  wire [23:0] chan_b_active_power_offset_o, chan_b_reactive_power_offset_o;
  wire [23:0] chan_b_apparent_power_offset_o;
  logic [31:0] rdat;
  logic [11:0] gidx[4] = '{12'h28c, 12'h28e, 12'h28f, 12'h290};
  logic [11:0] oidx[4] = '{12'h292, 12'h295, 12'h296, 12'h297};
  logic [15:0] cv[4] = '{16'h0000, 16'hff7f, 16'h1049, 16'h2012};
  int mismatches = 0, checked = 0, n;
  always #10 core_clk_i = ~core_clk_i;
  mcr_bank #(.REVERSE_POWER_PIN_HALF(4)) u_dut (.*);
  mcr_host u_host (.core_clk_i(core_clk_i), .pready_i(pready_o), .pslverr_i(pslverr_o),
    .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
    .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task acc(input logic w, input logic [11:0] i, input logic [31:0] d);
    u_host.xfer(w, i, d, rdat, rerr, to);
    if (to) begin
      mismatches++;
      test_done;
    end
  endtask
  task rd(input string nm, input logic [11:0] i, input logic [31:0] e);
    acc(0, i, 0);
    chk(nm, rdat, e);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask
  task t_reset;
    foreach (gidx[k]) rd("gain", gidx[k], 32'h400000);
    foreach (oidx[k]) rd("offset", oidx[k], 0);
    rd("noload", 12'h001, 0);
    rd("cycle", 12'h004, 32'h40);
    rd("cfg", 12'h102, 32'h8004);
    $display("test reset done");
  endtask
  task t_rw;
    foreach (gidx[k]) begin
      acc(1, gidx[k], 32'h123450 + k);
      rd("gain", gidx[k], 32'h123450 + k);
    end
    foreach (oidx[k]) begin
      acc(1, oidx[k], 32'h800001 + k);
      rd("offset", oidx[k], 32'hff800001 + k);
    end
    chk("offset port", {8'h0, chan_b_apparent_power_offset_o}, 32'h800004);
    acc(1, 12'h001, 32'hff);
    rd("noload", 12'h001, 32'h7);
    chk("noload port", {29'h0, noload_off_o}, 32'h7);
    acc(1, 12'h004, 32'h2a);
    rd("cycle", 12'h004, 32'h2a);
    chk("cycle port", {25'h0, clear_on_read_enable_o, cycle_accum_o}, 32'h2a);
    rd("last", 12'h2ff, 32'h2a);
    acc(0, 12'h3ff, 0);
    chk("unmapped", {31'h0, rerr}, 1);
    rd("last", 12'h2ff, 32'h2a);
    $display("test rw done");
  endtask
  task t_cfg;
    foreach (cv[k]) begin
      acc(1, 12'h102, cv[k]);
      rd("cfg", 12'h102, cv[k] & 16'hb97f);
      chk("cfg ports", {chan_a_integrator_on_o, chan_b_integrator_on_o, highpass_filter_on_o,
        power_factor_source_o, zero_cross_filter_bypass_o, checksum_on_o,
        current_zero_cross_source_o, zero_cross_irq_edge_o, disable_a_on_o},
        {cv[k][0], cv[k][1], cv[k][2], cv[k][3], cv[k][6], cv[k][8], cv[k][11],
        cv[k][13:12], ~cv[k][15]});
    end
    acc(1, 12'h28c, 32'h1);
    acc(1, 12'h102, 32'h80);
    rd("gain", 12'h28c, 32'h400000);
    rd("cfg", 12'h102, 32'h8004);
    acc(0, 12'h3f0, 0);
    chk("soft_reset_request flag", {31'h0, rdat[0]}, 1);
    acc(1, 12'h3f0, 32'h7);
    $display("test cfg done");
  endtask
  task t_reverse_power_pin;
    acc(1, 12'h102, 0);
    rev_polarity_two_i <= 1;
    cyc(4);
    chk("pin source", {31'h0, reverse_power_pin_o}, 0);
    rev_polarity_one_i <= 1;
    cyc(4);
    chk("pin level", {31'h0, reverse_power_pin_o}, 1);
    rev_polarity_one_i <= 0;
    acc(1, 12'h102, 32'h30);
    chk("irq masked", {31'h0, irq_o}, 0);
    cyc(4);
    n = 0;
    repeat (16) begin
      @(posedge core_clk_i);
      n += reverse_power_pin_o;
    end
    chk("pulse count", n, 8);
    acc(1, 12'h3f1, 32'h2);
    cyc(2);
    chk("irq set", {31'h0, irq_o}, 1);
    rev_polarity_two_i <= 0;
    cyc(12);
    chk("pin idle", {31'h0, reverse_power_pin_o}, 0);
    acc(1, 12'h3f0, 32'h7);
    cyc(2);
    chk("irq clear", {31'h0, irq_o}, 0);
    $display("test reverse_power_pin done");
  endtask
  task t_zx;
    for (int e = 0; e < 4; e++) begin
      acc(1, 12'h102, e << 12);
      for (int lv = 1; lv >= 0; lv--) begin
        voltage_zero_cross_i <= lv[0];
        n = 0;
        repeat (6) begin
          @(posedge core_clk_i);
          n += zero_cross_irq_o;
        end
        chk("zero_cross_irq_edge", n, (lv == 1) ? (e != 1) : (e != 2));
      end
    end
    $display("test zx done");
  endtask
  initial begin
    cyc(8);
    rst_b_i <= 1;
    cyc(1);
    t_reset;
    t_rw;
    t_cfg;
    t_reverse_power_pin;
    t_zx;
    test_done;
  end
endmodule
